//--- tap_regs.svh
// Register indexes, field positions, reset values and timing counts of the status block.
`ifndef TAP_REGS_SVH
`define TAP_REGS_SVH

// ----------------------------------------------------------------
// Register indexes; the byte address on the bus is four times these.
// ----------------------------------------------------------------
`define TAP_IDX_ADVERTISE 8'h68
`define TAP_IDX_PARTNER 8'h6a
`define TAP_IDX_STATUS 8'h6c

// ----------------------------------------------------------------
// Advertisement and partner ability field positions.
// ----------------------------------------------------------------
`define TAP_BIT_MORE_PAGES 15
`define TAP_BIT_PARTNER_ACK 14
`define TAP_BIT_RF_HI 13
`define TAP_BIT_RF_LO 12
`define TAP_BIT_ASYM 8
`define TAP_BIT_SYM 7
`define TAP_BIT_HALF_DUP 6
`define TAP_BIT_FULL_DUP 5
`define TAP_RST_RF 2'h0
`define TAP_RST_PAUSE 1'h0

// ----------------------------------------------------------------
// Status byte field positions.
// ----------------------------------------------------------------
`define TAP_ST_TEN_BIT 7
`define TAP_ST_TX_PAUSE 6
`define TAP_ST_RX_PAUSE 5
`define TAP_ST_GIG_FULL 4
`define TAP_ST_FAST 3
`define TAP_ST_LEGACY 2
`define TAP_ST_LINK 1
`define TAP_ST_FULL 0

// ----------------------------------------------------------------
// Management polling: PHY address, frame layout and timing.
// ----------------------------------------------------------------
`define TAP_PHY_ADDR 5'h01
`define TAP_MDIO_START_READ 4'h6
`define TAP_POLL_REGS 6
`define TAP_PREAMBLE_BITS 32
`define TAP_FRAME_BITS 64
`define TAP_DRIVEN_BITS 46
`define TAP_READ_FIRST_BIT 48
`define TAP_CLK_PERIOD_NS 10
`define TAP_MDC_PERIOD_NS 320
`define TAP_MDC_HALF_CYC (`TAP_MDC_PERIOD_NS / `TAP_CLK_PERIOD_NS / 2)

// ----------------------------------------------------------------
// Polled PHY registers and the bits read from them.
// ----------------------------------------------------------------
`define TAP_MII_CTRL 5'h00
`define TAP_MII_STAT 5'h01
`define TAP_MII_ADV 5'h04
`define TAP_MII_LPA 5'h05
`define TAP_MII_GCTRL 5'h09
`define TAP_MII_GSTAT 5'h0a
`define TAP_CTRL_SPEED_LSB 13
`define TAP_CTRL_AN_EN 12
`define TAP_CTRL_DUPLEX 8
`define TAP_CTRL_SPEED_MSB 6
`define TAP_STAT_LINK 2
`define TAP_ABIL_100_FULL 8
`define TAP_ABIL_100_HALF 7
`define TAP_ABIL_10_FULL 6
`define TAP_GCTRL_1000_FULL 9
`define TAP_GSTAT_1000_FULL 11

`endif

//--- tap_pkg.sv
// Types shared by the status register block and its management reader.
package tap_pkg;

  // Classic Wishbone request from the master.
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [9:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } tap_wb_req_s;

  // Management pins; the data pin is split into output and enable.
  typedef struct packed {
    logic mdc;
    logic mdio_out;
    logic mdio_oe;
  } tap_mdio_pins_s;

  // State of the management frame reader.
  typedef struct packed {
    logic busy;
    logic [4:0] div;
    logic [6:0] idx;
    logic [45:0] sh;
    logic [15:0] rdata;
    logic done;
    tap_mdio_pins_s pins;
  } tap_mdio_st_s;

  // Polling sequencer states.
  typedef enum logic {TAP_POLL_ISSUE, TAP_POLL_WAIT} tap_poll_e;

  // Copies of the six polled PHY registers.
  typedef logic [5:0][15:0] tap_phy_regs_t;

  // State of the register block.
  typedef struct packed {
    logic ack;
    logic [31:0] rdat;
    logic [1:0] rf;
    logic sym;
    logic asym;
    logic [15:0] lp;
    logic tbi_mode;
    tap_phy_regs_t phy;
    logic [2:0] pidx;
    tap_poll_e poll;
    logic start;
    logic [7:0] stat;
  } tap_regs_st_s;

endpackage : tap_pkg

//--- tap_mdio_read.sv
// Management read frame engine: preamble, read opcode, turnaround, 16 data bits.
`timescale 1ns/1ps
`include "tap_regs.svh"

module tap_mdio_read (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic start,
  input wire logic [4:0] reg_addr,
  input wire logic mdio_in,
  output tap_pkg::tap_mdio_pins_s pins,
  output logic done,
  output logic [15:0] rdata
);

  tap_pkg::tap_mdio_st_s st_ff;
  tap_pkg::tap_mdio_st_s nxt_st;

  // ----------------------------------------------------------------
  // Frame sequencing.
  // ----------------------------------------------------------------

  // Clock low half first; data changes on the falling edge, sampled on the rising.
  always_comb begin
    nxt_st = st_ff;
    nxt_st.done = 1'b0;
    if (!st_ff.busy) begin
      if (start) begin
        nxt_st.busy = 1'b1;
        nxt_st.div = 5'h00;
        nxt_st.idx = 7'h00;
        nxt_st.sh = {{`TAP_PREAMBLE_BITS{1'b1}}, `TAP_MDIO_START_READ, `TAP_PHY_ADDR, reg_addr};
        nxt_st.pins.mdc = 1'b0;
        nxt_st.pins.mdio_out = 1'b1;
        nxt_st.pins.mdio_oe = 1'b1;
      end
    end else if (st_ff.div == 5'(`TAP_MDC_HALF_CYC - 1)) begin
      nxt_st.div = 5'h00;
      nxt_st.pins.mdc = ~st_ff.pins.mdc;
      if (!st_ff.pins.mdc) begin
        // Rising edge: the PHY's data bits are taken here.
        if (st_ff.idx >= 7'(`TAP_READ_FIRST_BIT)) begin
          nxt_st.rdata = {st_ff.rdata[14:0], mdio_in};
        end
      end else if (st_ff.idx == 7'(`TAP_FRAME_BITS - 1)) begin
        // Last falling edge closes the frame and hands over the word.
        nxt_st.busy = 1'b0;
        nxt_st.done = 1'b1;
        nxt_st.pins.mdio_oe = 1'b0;
      end else begin
        nxt_st.idx = st_ff.idx + 7'h01;
        nxt_st.sh = {st_ff.sh[44:0], 1'b0};
        nxt_st.pins.mdio_out = st_ff.sh[44];
        nxt_st.pins.mdio_oe = (st_ff.idx + 7'h01) < 7'(`TAP_DRIVEN_BITS);
      end
    end else begin
      nxt_st.div = st_ff.div + 5'h01;
    end
  end

  // State register.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pins = st_ff.pins;
  assign done = st_ff.done;
  assign rdata = st_ff.rdata;

endmodule : tap_mdio_read

//--- tap_status_regs.sv
// Auto-negotiation ability registers and PHY link status byte on a Wishbone slave.
//
// Local design decision: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "tap_regs.svh"

module tap_status_regs (
  input wire logic clk,
  input wire logic sys_rst,
  input tap_pkg::tap_wb_req_s wb_req,
  output logic wb_ack,
  output logic [31:0] wb_dat,
  input wire logic eeprom_load,
  input wire logic eeprom_ten_bit,
  input wire logic flow_tx_en,
  input wire logic flow_rx_en,
  input wire logic tbi_link_ok,
  input wire logic tbi_an_done,
  input wire logic [15:0] tbi_rx_page,
  input wire logic mdio_in,
  output tap_pkg::tap_mdio_pins_s mdio_pins,
  output logic [7:0] link_status
);

  tap_pkg::tap_regs_st_s st_ff;
  tap_pkg::tap_regs_st_s nxt_st;
  logic mdio_done;
  logic [15:0] mdio_rdata;
  logic [4:0] poll_addr;
  logic [3:0] resolved;
  logic [7:0] stat_now;

  // ----------------------------------------------------------------
  // Decoding helpers.
  // ----------------------------------------------------------------

  // Maps a slot of the polling loop to its PHY register address.
  function automatic logic [4:0] poll_reg(input logic [2:0] slot);
    logic [4:0] a;
    a = `TAP_MII_CTRL;
    case (slot)
      3'h1: a = `TAP_MII_STAT;
      3'h2: a = `TAP_MII_ADV;
      3'h3: a = `TAP_MII_LPA;
      3'h4: a = `TAP_MII_GCTRL;
      3'h5: a = `TAP_MII_GSTAT;
      default: a = `TAP_MII_CTRL;
    endcase
    return a;
  endfunction : poll_reg

  // Resolves {gigabit full, 100, 10, full duplex} from the polled copies.
  function automatic logic [3:0] resolve(input tap_pkg::tap_phy_regs_t r);
    logic [15:0] common;
    logic [1:0] spd;
    logic full;
    logic [3:0] res;
    common = r[2] & r[3];
    spd = {r[0][`TAP_CTRL_SPEED_MSB], r[0][`TAP_CTRL_SPEED_LSB]};
    full = r[0][`TAP_CTRL_DUPLEX];
    res = 4'h0;
    if (!r[0][`TAP_CTRL_AN_EN]) begin
      // Forced mode: speed and duplex come from the control register.
      res = {(spd == 2'h2) & full, spd == 2'h1, spd == 2'h0, full};
    end else if (r[4][`TAP_GCTRL_1000_FULL] & r[5][`TAP_GSTAT_1000_FULL]) begin
      res = 4'h9;
    end else if (common[`TAP_ABIL_100_FULL]) begin
      res = 4'h5;
    end else if (common[`TAP_ABIL_100_HALF]) begin
      res = 4'h4;
    end else if (common[`TAP_ABIL_10_FULL]) begin
      res = 4'h3;
    end else begin
      res = 4'h2;
    end
    return res;
  endfunction : resolve

  // Tells whether a word address hits one of the three registers.
  function automatic logic is_mapped(input logic [7:0] idx);
    logic hit;
    if (idx == `TAP_IDX_ADVERTISE) begin
      hit = 1'b1;
    end else if (idx == `TAP_IDX_PARTNER) begin
      hit = 1'b1;
    end else if (idx == `TAP_IDX_STATUS) begin
      hit = 1'b1;
    end else begin
      hit = 1'b0;
    end
    return hit;
  endfunction : is_mapped

  // Builds the read word for a register index; unmapped reads as zero.
  function automatic logic [31:0] read_word(input logic [7:0] idx,
                                            input tap_pkg::tap_regs_st_s s);
    logic [31:0] w;
    w = 32'h0000_0000;
    if (idx == `TAP_IDX_ADVERTISE) begin
      w[`TAP_BIT_RF_HI:`TAP_BIT_RF_LO] = s.rf;
      w[`TAP_BIT_ASYM] = s.asym;
      w[`TAP_BIT_SYM] = s.sym;
      w[`TAP_BIT_FULL_DUP] = 1'b1;
    end else if (idx == `TAP_IDX_PARTNER) begin
      w[15:0] = s.lp;
    end else if (idx == `TAP_IDX_STATUS) begin
      w[7:0] = s.stat;
    end
    return w;
  endfunction : read_word

  // ----------------------------------------------------------------
  // Management reader.
  // ----------------------------------------------------------------

  // One frame at a time; the sequencer below walks the six registers.
  tap_mdio_read u_mdio (
    .clk(clk),
    .sys_rst(sys_rst),
    .start(st_ff.start),
    .reg_addr(poll_addr),
    .mdio_in(mdio_in),
    .pins(mdio_pins),
    .done(mdio_done),
    .rdata(mdio_rdata)
  );

  assign poll_addr = poll_reg(st_ff.pidx);

  // ----------------------------------------------------------------
  // Status byte.
  // ----------------------------------------------------------------

  // Speed bits hold zero without a link, and in ten-bit mode.
  always_comb begin
    resolved = resolve(st_ff.phy);
    stat_now = 8'h00;
    stat_now[`TAP_ST_TEN_BIT] = st_ff.tbi_mode;
    stat_now[`TAP_ST_TX_PAUSE] = flow_tx_en;
    stat_now[`TAP_ST_RX_PAUSE] = flow_rx_en;
    if (st_ff.tbi_mode) begin
      stat_now[`TAP_ST_LINK] = tbi_link_ok;
      stat_now[`TAP_ST_FULL] = tbi_link_ok;
    end else if (st_ff.phy[1][`TAP_STAT_LINK]) begin
      stat_now[`TAP_ST_GIG_FULL] = resolved[3];
      stat_now[`TAP_ST_FAST] = resolved[2];
      stat_now[`TAP_ST_LEGACY] = resolved[1];
      stat_now[`TAP_ST_LINK] = 1'b1;
      stat_now[`TAP_ST_FULL] = resolved[0];
    end
  end

  // ----------------------------------------------------------------
  // Next state: bus slave, strap, partner capture, polling loop.
  // ----------------------------------------------------------------

  // A request is answered with ack one cycle after it is seen.
  always_comb begin
    nxt_st = st_ff;
    nxt_st.start = 1'b0;
    nxt_st.stat = stat_now;
    nxt_st.ack = wb_req.cyc & wb_req.stb & ~st_ff.ack;
    if (wb_req.cyc & wb_req.stb & ~st_ff.ack) begin
      nxt_st.rdat = read_word(wb_req.adr[9:2], st_ff);
      if (wb_req.we && is_mapped(wb_req.adr[9:2]) &&
          wb_req.adr[9:2] == `TAP_IDX_ADVERTISE) begin
        if (wb_req.sel[1]) begin
          nxt_st.rf = wb_req.dat[`TAP_BIT_RF_HI:`TAP_BIT_RF_LO];
          nxt_st.asym = wb_req.dat[`TAP_BIT_ASYM];
        end
        if (wb_req.sel[0]) begin
          nxt_st.sym = wb_req.dat[`TAP_BIT_SYM];
        end
      end
    end
    // Interface mode follows the value loaded from the EEPROM.
    if (eeprom_load) begin
      nxt_st.tbi_mode = eeprom_ten_bit;
    end
    // Base page of the finished negotiation; held until the next one.
    if (tbi_an_done) begin
      nxt_st.lp = 16'h0000;
      nxt_st.lp[`TAP_BIT_MORE_PAGES] = tbi_rx_page[`TAP_BIT_MORE_PAGES];
      nxt_st.lp[`TAP_BIT_PARTNER_ACK] = tbi_rx_page[`TAP_BIT_PARTNER_ACK];
      nxt_st.lp[`TAP_BIT_RF_HI:`TAP_BIT_RF_LO] =
        tbi_rx_page[`TAP_BIT_RF_HI:`TAP_BIT_RF_LO];
      nxt_st.lp[`TAP_BIT_ASYM:`TAP_BIT_SYM] =
        tbi_rx_page[`TAP_BIT_ASYM:`TAP_BIT_SYM];
      nxt_st.lp[`TAP_BIT_HALF_DUP] = tbi_rx_page[`TAP_BIT_HALF_DUP];
      nxt_st.lp[`TAP_BIT_FULL_DUP] = tbi_rx_page[`TAP_BIT_FULL_DUP];
    end
    // Endless polling loop over the six PHY registers.
    case (st_ff.poll)
      tap_pkg::TAP_POLL_ISSUE: begin
        nxt_st.start = 1'b1;
        nxt_st.poll = tap_pkg::TAP_POLL_WAIT;
      end
      tap_pkg::TAP_POLL_WAIT: begin
        if (mdio_done) begin
          nxt_st.phy[st_ff.pidx] = mdio_rdata;
          if (st_ff.pidx == 3'(`TAP_POLL_REGS - 1)) begin
            nxt_st.pidx = 3'h0;
          end else begin
            nxt_st.pidx = st_ff.pidx + 3'h1;
          end
          nxt_st.poll = tap_pkg::TAP_POLL_ISSUE;
        end
      end
      default: begin
        nxt_st.poll = tap_pkg::TAP_POLL_ISSUE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State register.
  // ----------------------------------------------------------------

  // Every field starts from zero; the poll loop starts at slot zero.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_ff <= '0;
      st_ff.rf <= `TAP_RST_RF;
      st_ff.sym <= `TAP_RST_PAUSE;
      st_ff.asym <= `TAP_RST_PAUSE;
      st_ff.poll <= tap_pkg::TAP_POLL_ISSUE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs.
  // ----------------------------------------------------------------

  // Bus answer and status byte come straight from the state register.
  assign wb_ack = st_ff.ack;
  assign wb_dat = st_ff.rdat;
  assign link_status = st_ff.stat;

endmodule : tap_status_regs

//--- tap_status_regs_chk.sv
// Concurrent checks on the ports of the status register block.
`timescale 1ns/1ps

module tap_status_regs_chk (
  input wire logic clk,
  input wire logic sys_rst,
  input tap_pkg::tap_wb_req_s wb_req,
  input wire logic wb_ack,
  input wire logic [31:0] wb_dat,
  input wire logic flow_tx_en,
  input wire logic flow_rx_en,
  input tap_pkg::tap_mdio_pins_s mdio_pins,
  input wire logic [7:0] link_status
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  logic [4:0] hi_ff;
  logic [10:0] oe_ff;

  // Counts cycles of management clock high and of the drive window.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hi_ff <= 5'h00;
      oe_ff <= 11'h000;
    end else begin
      hi_ff <= mdio_pins.mdc ? hi_ff + 5'h01 : 5'h00;
      oe_ff <= mdio_pins.mdio_oe ? oe_ff + 11'h001 : 11'h000;
    end
  end

  property p_adv;
    wb_ack && $past(!wb_req.we && wb_req.adr == 10'h1a0) |-> (wb_dat & ~32'h3180) == 32'h20;
  endproperty
  a_adv: assert property (p_adv) else $error("advertise fixed bits wrong");
  property p_partner;
    wb_ack && $past(!wb_req.we && wb_req.adr == 10'h1a8) |-> (wb_dat & ~32'hf1e0) == 32'h0;
  endproperty
  a_partner: assert property (p_partner) else $error("partner reserved bits set");
  property p_status;
    wb_ack && $past(!wb_req.we && wb_req.adr == 10'h1b0) |-> wb_dat == {24'h0, $past(link_status)};
  endproperty
  a_status: assert property (p_status) else $error("status read differs");
  property p_flow;
    !$past(sys_rst) |-> link_status[6:5] == $past({flow_tx_en, flow_rx_en});
  endproperty
  a_flow: assert property (p_flow) else $error("flow bits stale");
  property p_tenbit;
    link_status[7] |-> link_status[4:2] == 3'h0 && link_status[1] == link_status[0];
  endproperty
  a_tenbit: assert property (p_tenbit) else $error("ten-bit status wrong");
  property p_nolink;
    !link_status[1] |-> link_status[4:0] == 5'h00;
  endproperty
  a_nolink: assert property (p_nolink) else $error("speed without link");
  property p_speed;
    link_status[1] && !link_status[7] |-> $onehot(link_status[4:2]) && (!link_status[4] || link_status[0]);
  endproperty
  a_speed: assert property (p_speed) else $error("speed bits wrong");
  property p_mdc;
    $fell(mdio_pins.mdc) |-> hi_ff == 5'h10;
  endproperty
  a_mdc: assert property (p_mdc) else $error("mdc high time wrong");
  property p_oe;
    $fell(mdio_pins.mdio_oe) |-> oe_ff == 11'h5c0;
  endproperty
  a_oe: assert property (p_oe) else $error("drive window wrong");
endmodule : tap_status_regs_chk

bind tap_status_regs tap_status_regs_chk u_tap_status_regs_chk (
  .clk(clk), .sys_rst(sys_rst), .wb_req(wb_req), .wb_ack(wb_ack), .wb_dat(wb_dat),
  .flow_tx_en(flow_tx_en), .flow_rx_en(flow_rx_en), .mdio_pins(mdio_pins),
  .link_status(link_status)
);

//--- tap_phy_model.sv
// Behavioural PHY that answers the block's management read frames.
`timescale 1ns/1ps

module tap_phy_model (
  input tap_pkg::tap_mdio_pins_s pins,
  output logic mdio_in
);
  logic [15:0] regs [32];
  logic [9:0] addr = 10'h000;
  logic drv = 1'b0;
  int cnt = 100;

  // Clears the register copies; the bench loads its own values later.
  initial begin
    foreach (regs[i]) regs[i] = 16'h0000;
  end

  // Restarts the bit count when the block begins a frame.
  always @(posedge pins.mdio_oe) cnt = 0;

  // Shifts in the PHY and register address bits on rising clock edges.
  always @(posedge pins.mdc) begin
    if (cnt >= 36 && cnt < 46) addr = {addr[8:0], pins.mdio_out};
    cnt = cnt + 1;
  end

  // Answers only its own address; a released line floats up to the pull-up level.
  always @(negedge pins.mdc) begin
    if (cnt >= 48 && cnt < 64 && addr[9:5] == 5'h01) begin
      drv <= regs[addr[4:0]][63 - cnt];
    end else begin
      drv <= 1'b1;
    end
  end

  // Resolves the shared data wire from both drivers.
  assign mdio_in = pins.mdio_oe ? pins.mdio_out : drv;
endmodule : tap_phy_model

//--- test_tap_status_regs.sv
// Self-checking bench for the status register block.
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, b); end end

module test_tap_status_regs;
  localparam int RIDX [6] = '{0, 1, 4, 5, 9, 10};
  localparam logic [15:0] CFG [4][6] = '{
    '{16'h1000, 16'h0004, 16'h0000, 16'h0000, 16'h0200, 16'h0800},
    '{16'h1000, 16'h0004, 16'h0100, 16'h0100, 16'h0000, 16'h0000},
    '{16'h1000, 16'h0004, 16'h0000, 16'h0000, 16'h0000, 16'h0000},
    '{16'h1000, 16'h0000, 16'h0000, 16'h0000, 16'h0200, 16'h0800}};
  localparam logic [4:0] CEXP [4] = '{5'h13, 5'h0b, 5'h06, 5'h00};
  logic clk, wb_ack, mdio_in;
  logic sys_rst = 1'b1, eeprom_load = 1'b0, eeprom_ten_bit = 1'b0, tbi_an_done = 1'b0;
  logic flow_tx_en = 1'b0, flow_rx_en = 1'b0, tbi_link_ok = 1'b0;
  logic [15:0] tbi_rx_page = 16'h0000;
  logic [31:0] wb_dat, d, lp, ev;
  logic [31:0] seed = 32'h63;
  logic [7:0] link_status;
  tap_pkg::tap_wb_req_s wb_req = '0;
  tap_pkg::tap_mdio_pins_s mdio_pins;
  logic [31:0] exp_q[$];
  int err_count = 0, total_checks = 0, cyc_n = 0;

  tap_status_regs u_tap_status_regs (
    .clk(clk), .sys_rst(sys_rst), .wb_req(wb_req), .wb_ack(wb_ack), .wb_dat(wb_dat),
    .eeprom_load(eeprom_load), .eeprom_ten_bit(eeprom_ten_bit), .flow_tx_en(flow_tx_en),
    .flow_rx_en(flow_rx_en), .tbi_link_ok(tbi_link_ok), .tbi_an_done(tbi_an_done),
    .tbi_rx_page(tbi_rx_page), .mdio_in(mdio_in), .mdio_pins(mdio_pins),
    .link_status(link_status));
  tap_phy_model u_tap_phy_model (.pins(mdio_pins), .mdio_in(mdio_in));

  // Free-running 100 MHz clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Prints the verdict and ends the run.
  task automatic give_verdict();
    if (err_count == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : give_verdict

  // Cuts a hung run short.
  always @(posedge clk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 80000) begin
      err_count++;
      give_verdict();
    end
  end

  // Compares each read answer with the oldest noted expectation.
  always @(posedge clk) begin
    if (wb_ack === 1'b1 && !wb_req.we) begin
      ev = exp_q.pop_front();
      `CHK(wb_dat, ev)
    end
  end

  // Next value of the xorshift sequence.
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  // One classic bus cycle, held until acknowledged.
  task automatic wb(input logic we, input logic [9:0] a, input logic [31:0] v, input logic [3:0] s);
    wb_req <= '{1'b1, 1'b1, we, a, s, v};
    do @(posedge clk); while (wb_ack !== 1'b1);
    wb_req <= '0;
    @(posedge clk);
  endtask : wb

  // Read that notes its expected answer first.
  task automatic rd(input logic [9:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    wb(1'b0, a, 32'h0, 4'hf);
  endtask : rd

  // ----------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    rd(10'h1a0, 32'h20);
    rd(10'h1fc, 32'h0);
    rd(10'h1b0, 32'h0);
    for (int k = 0; k < 4; k++) begin
      d = xs();
      d[13:12] = k[1:0];
      d[8:7] = k[1:0];
      wb(1'b1, 10'h1a0, d, 4'hf);
      rd(10'h1a0, d & 32'h3180 | 32'h20);
    end
    wb(1'b1, 10'h1a0, 32'h0, 4'hf);
    wb(1'b1, 10'h1a0, 32'hffffffff, 4'h1);
    rd(10'h1a0, 32'ha0);
    wb(1'b1, 10'h1a0, 32'hffffffff, 4'h2);
    rd(10'h1a0, 32'h31a0);
    wb(1'b1, 10'h1a8, 32'hffffffff, 4'hf);
    rd(10'h1a8, 32'h0);
    for (int k = 0; k < 4; k++) begin
      lp = (k == 0) ? 32'hffff : xs();
      tbi_rx_page <= lp[15:0];
      tbi_an_done <= 1'b1;
      @(posedge clk);
      tbi_an_done <= 1'b0;
      tbi_rx_page <= ~lp[15:0];
      rd(10'h1a8, lp & 32'hf1e0);
    end
    for (int k = 0; k < 4; k++) begin
      for (int r = 0; r < 6; r++) u_tap_phy_model.regs[RIDX[r]] = CFG[k][r];
      d = xs();
      flow_tx_en <= d[1];
      flow_rx_en <= d[0];
      repeat (14500) @(posedge clk);
      `CHK(link_status, {1'b0, d[1:0], CEXP[k]})
      rd(10'h1b0, {24'h0, 1'b0, d[1:0], CEXP[k]});
    end
    eeprom_ten_bit <= 1'b1;
    eeprom_load <= 1'b1;
    tbi_link_ok <= 1'b1;
    @(posedge clk);
    eeprom_load <= 1'b0;
    eeprom_ten_bit <= 1'b0;
    repeat (4) @(posedge clk);
    rd(10'h1b0, {24'h0, 1'b1, d[1:0], 5'h03});
    tbi_link_ok <= 1'b0;
    repeat (4) @(posedge clk);
    rd(10'h1b0, {24'h0, 1'b1, d[1:0], 5'h00});
    repeat (2) @(posedge clk);
    give_verdict();
  end
endmodule : test_tap_status_regs
